// ---- rtl/tac_config_regs.sv ----
// touch acquisition config slice: burst lengths, discharge sources, spread, pad drive
// assumes a synchronous APB master on pclk and an acquisition sequencer outside
// How it works
// - each burst field gives the repeat count of the switching sequence per channel.
// - request flag stays high while waiting for burst values.
// - force bit n holds source n on while global enable is set, otherwise its enable decides.
// - global enable gates every discharge source.
// - voltage select picks band gap at 0, one third supply at 1.
// - resistor select picks external discharge pin resistor at 0, internal at 1.
// - trim field drives discharge current, zero minimum, 0x1f maximum.
// - enable bit n lets source n on during acquisition phases.
// - spread deviation bounds pulse lengthening or shortening in prescaled cycles.
// - group a pad bit one selects resistive drive during burst.
// - group b pad bit one selects resistive drive during burst.
// - base count register reads the sensor's base count in low bits.
// - current count register reads the latest sensor count in low bits.
// - request flag reads one only when the current x line needs lengths.
//
// Added by the designer: the APB slave port.
`include "tac_map.svh"
module tac_config_regs
    import tac_pkg::*;
#(
    parameter int Y_COUNT_W = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic matrix_line_start,
    input wire logic [Y_COUNT_W-1:0] matrix_y_count,
    output logic burst_value_request,
    output logic matrix_resume,
    output logic [8*64-1:0] repeat_length_field,
    output logic [7:0] discharge_on,
    output logic discharge_global_enable,
    output logic ref_voltage_select,
    output logic ref_resistor_select,
    output logic [4:0] discharge_trim,
    output logic [7:0] spread_max_deviation,
    input wire logic burst_phase,
    output logic [`TAC_PAD_BITS-1:0] sense_pad_group_a_res,
    output logic [`TAC_PAD_BITS-1:0] sense_pad_group_b_res,
    input wire logic [15:0] sensor_base_count,
    input wire logic [15:0] sensor_current_count,
    input wire logic [7:0] source_phase,
    output logic irq
);
    // ****************
    // bus decode
    // ****************
    logic wr;
    logic [31:0] rd_mux;
    logic mapped;
    tac_disch_t disch;
    logic [7:0] spread;
    logic [`TAC_PAD_BITS-1:0] pad_a;
    logic [`TAC_PAD_BITS-1:0] pad_b;
    logic [`TAC_EV_BITS-1:0] ev_status;
    logic [`TAC_EV_BITS-1:0] ev_mask;
    logic [`TAC_EV_BITS-1:0] ev_set;
    tac_state_t state;
    logic [Y_COUNT_W-1:0] y_total;
    logic [Y_COUNT_W-1:0] y_done;
    logic [Y_COUNT_W-1:0] next_y_done;
    logic [31:0] burst_word;
    // reset image unpacked field by field: register layout has unused gaps that the packed struct lacks
    localparam logic [31:0] DISCH_RST = `TAC_DISCH_RESET;
    localparam tac_disch_t DISCH_RST_FIELDS = '{
        force_discharge_on: DISCH_RST[`TAC_FORCE_LSB +: 8],
        discharge_global_enable: DISCH_RST[`TAC_DISCHARGE_GLOBAL_ENABLE_BIT],
        ref_voltage_select: DISCH_RST[`TAC_VREF_BIT],
        ref_resistor_select: DISCH_RST[`TAC_RREF_BIT],
        trim: DISCH_RST[`TAC_TRIM_LSB +: 5],
        source_enable: DISCH_RST[7:0]
    };
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `TAC_OFF_BURST: rd_mux = 32'h0000_0000;
            `TAC_OFF_DISCH: rd_mux = {disch.force_discharge_on, disch.discharge_global_enable,
                5'h00, disch.ref_voltage_select, disch.ref_resistor_select, 3'h0,
                disch.trim, disch.source_enable};
            `TAC_OFF_SPREAD: rd_mux = {24'h000000, spread};
            `TAC_OFF_PADA: rd_mux = {15'h0000, pad_a};
            `TAC_OFF_PADB: rd_mux = {15'h0000, pad_b};
            `TAC_OFF_BASE: rd_mux = {16'h0000, sensor_base_count};
            `TAC_OFF_CURR: rd_mux = {16'h0000, sensor_current_count};
            `TAC_OFF_STATUS: rd_mux = {29'h0, burst_value_request, ev_status};
            `TAC_OFF_CLEAR: rd_mux = 32'h0000_0000;
            `TAC_OFF_MASK: rd_mux = {30'h0, ev_mask};
            default: mapped = 1'b0;
        endcase
    end
    // unmapped addresses answer an error in the same single access cycle
    assign pslverr = psel & penable & ~mapped;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end
    // ****************
    // configuration registers
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disch <= DISCH_RST_FIELDS;
            spread <= 8'h00;
            pad_a <= '0;
            pad_b <= '0;
        end else if (wr) begin
            case (paddr)
                `TAC_OFF_DISCH: begin
                    disch.force_discharge_on <= pwdata[`TAC_FORCE_LSB +: 8];
                    disch.discharge_global_enable <= pwdata[`TAC_DISCHARGE_GLOBAL_ENABLE_BIT];
                    disch.ref_voltage_select <= pwdata[`TAC_VREF_BIT];
                    disch.ref_resistor_select <= pwdata[`TAC_RREF_BIT];
                    disch.trim <= pwdata[`TAC_TRIM_LSB +: 5];
                    disch.source_enable <= pwdata[7:0];
                end
                `TAC_OFF_SPREAD: spread <= pwdata[7:0];
                `TAC_OFF_PADA: pad_a <= pwdata[`TAC_PAD_BITS-1:0];
                `TAC_OFF_PADB: pad_b <= pwdata[`TAC_PAD_BITS-1:0];
                default: ;
            endcase
        end
    end
    // ****************
    // discharge source outputs
    // ****************
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            // forcing is for test only; it bypasses the acquisition phase gating
            discharge_on[n] = disch.discharge_global_enable &
                (disch.force_discharge_on[n] |
                (disch.source_enable[n] & source_phase[n]));
        end
    end
    assign discharge_global_enable = disch.discharge_global_enable;
    assign ref_voltage_select = disch.ref_voltage_select;
    assign ref_resistor_select = disch.ref_resistor_select;
    assign discharge_trim = disch.trim;
    assign spread_max_deviation = spread;
    // resistive drive only matters while bursting
    assign sense_pad_group_a_res = burst_phase ? pad_a : '0;
    assign sense_pad_group_b_res = burst_phase ? pad_b : '0;
    // ****************
    // burst length handshake
    // ****************
    assign burst_word = pwdata;
    // compare one bit wider so that slots near the top of the count cannot wrap
    assign next_y_done = ({1'b0, y_done} + (Y_COUNT_W+1)'(4) > {1'b0, y_total}) ?
        y_total : y_done + Y_COUNT_W'(4);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= tac_idle;
            y_total <= '0;
            y_done <= '0;
            matrix_resume <= 1'b0;
        end else begin
            matrix_resume <= 1'b0;
            case (state)
                tac_idle: begin
                    if (matrix_line_start) begin
                        y_total <= matrix_y_count;
                        y_done <= '0;
                        state <= (matrix_y_count == '0) ? tac_run : tac_wait_burst;
                    end
                end
                tac_wait_burst: begin
                    if (wr && paddr == `TAC_OFF_BURST) begin
                        y_done <= next_y_done;
                        if (next_y_done == y_total) begin
                            state <= tac_run;
                        end
                    end
                end
                tac_run: begin
                    matrix_resume <= 1'b1;
                    state <= tac_idle;
                end
                default: state <= tac_idle;
            endcase
        end
    end
    assign burst_value_request = (state == tac_wait_burst);
    // byte 3-k of a write lands in slot y_done+k; top byte is the first y
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            repeat_length_field <= '0;
        end else if (wr && paddr == `TAC_OFF_BURST && state == tac_wait_burst) begin
            for (int k = 0; k < 4; k++) begin
                if (32'(y_done) + k < 64) begin
                    repeat_length_field[(32'(y_done) + k) * 8 +: 8] <= burst_word[31 - 8*k -: 8];
                end
            end
        end
    end
    // ****************
    // events and interrupt
    // ****************
    assign ev_set[`TAC_EV_REQ] = matrix_line_start & (state == tac_idle) & (matrix_y_count != '0);
    assign ev_set[`TAC_EV_DONE] = matrix_resume;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_status <= '0;
        end else begin
            // a set in the clearing cycle wins
            if (wr && paddr == `TAC_OFF_CLEAR) begin
                ev_status <= (ev_status & ~pwdata[`TAC_EV_BITS-1:0]) | ev_set;
            end else begin
                ev_status <= ev_status | ev_set;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_mask <= '0;
        end else if (wr && paddr == `TAC_OFF_MASK) begin
            ev_mask <= pwdata[`TAC_EV_BITS-1:0];
        end
    end
    assign irq = |(ev_status & ev_mask);
endmodule // tac_config_regs

// ---- rtl/tac_map.svh ----
// register offsets, field positions and reset values of the touch config slice
// assumes inclusion from the package and the top module only
`ifndef TAC_MAP_SVH
`define TAC_MAP_SVH
`define TAC_OFF_BURST 8'h58
`define TAC_OFF_DISCH 8'h5c
`define TAC_OFF_SPREAD 8'h60
`define TAC_OFF_PADA 8'h64
`define TAC_OFF_PADB 8'h68
`define TAC_OFF_BASE 8'h6c
`define TAC_OFF_CURR 8'h70
`define TAC_OFF_STATUS 8'h74
`define TAC_OFF_CLEAR 8'h40
`define TAC_OFF_MASK 8'h44
`define TAC_DISCH_RESET 32'h0000_0000
`define TAC_FORCE_LSB 24
`define TAC_DISCHARGE_GLOBAL_ENABLE_BIT 23
`define TAC_VREF_BIT 17
`define TAC_RREF_BIT 16
`define TAC_TRIM_LSB 8
`define TAC_PAD_BITS 17
`define TAC_EV_REQ 0
`define TAC_EV_DONE 1
`define TAC_EV_BITS 2
`endif

// ---- rtl/tac_pkg.sv ----
// types of the touch acquisition config slice
// assumes the map header sits beside it
package tac_pkg;
    `include "tac_map.svh"
    typedef struct packed {
        logic [7:0] force_discharge_on;
        logic discharge_global_enable;
        logic ref_voltage_select;
        logic ref_resistor_select;
        logic [4:0] trim;
        logic [7:0] source_enable;
    } tac_disch_t;
    typedef enum logic [1:0] {tac_idle, tac_wait_burst, tac_run} tac_state_t;
endpackage

// ---- testbench/tac_config_regs_sva.sv ----
// ****
// checker: burst request handshake, discharge and pad gating, count reads
// ****
// assumes binding into the config slice; presetn low resets everything
module tac_config_regs_sva #(
    parameter int Y_COUNT_W = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic matrix_line_start,
    input wire logic [Y_COUNT_W-1:0] matrix_y_count,
    input wire logic burst_value_request,
    input wire logic matrix_resume,
    input wire logic [7:0] discharge_on,
    input wire logic discharge_global_enable,
    input wire logic burst_phase,
    input wire logic [16:0] sense_pad_group_a_res,
    input wire logic [16:0] sense_pad_group_b_res,
    input wire logic [15:0] sensor_base_count,
    input wire logic [15:0] sensor_current_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bwr;
    assign bwr = psel && penable && pwrite && paddr == 8'h58;
    glob_gate_a: assert property (!discharge_global_enable |-> discharge_on == 8'h00)
        else $error("discharge source on while globally off");
    req_set_a: assert property (matrix_line_start && !burst_value_request &&
        !$past(burst_value_request) && !$past(matrix_line_start) &&
        matrix_y_count != 0 |=> burst_value_request) else $error("no request after start");
    req_hold_a: assert property (burst_value_request && !bwr |=> burst_value_request)
        else $error("request dropped without a burst write");
    req_drop_a: assert property ($fell(burst_value_request) |-> ##1 matrix_resume)
        else $error("no resume after request cleared");
    resume_once_a: assert property (matrix_resume |=> !matrix_resume)
        else $error("resume longer than one cycle");
    pad_gate_a: assert property (!burst_phase |->
        (sense_pad_group_a_res | sense_pad_group_b_res) == 17'h0) else $error("pad drive off burst");
    base_read_a: assert property (psel && !penable && !pwrite && paddr == 8'h6c
        |=> prdata == {16'h0, $past(sensor_base_count)}) else $error("base count read wrong");
    curr_read_a: assert property (psel && !penable && !pwrite && paddr == 8'h70
        |=> prdata == {16'h0, $past(sensor_current_count)}) else $error("count read wrong");
    cover property (matrix_resume);
    cover property ($rose(burst_value_request));
    cover property (bwr && burst_value_request);
endmodule // tac_config_regs_sva
bind tac_config_regs tac_config_regs_sva #(.Y_COUNT_W(Y_COUNT_W)) i_sva (.*);

// ---- testbench/tac_pad_model.sv ----
// ****
// far side: line sequencer, sensor counts, burst and source phases
// ****
// assumes pclk from the bench; kick comes from the bench's scenarios
module tac_pad_model (
    input wire logic pclk,
    input wire logic kick,
    input wire logic [4:0] ny,
    output logic matrix_line_start,
    output logic [4:0] matrix_y_count,
    output logic burst_phase,
    output logic [7:0] source_phase,
    output logic [15:0] sensor_base_count,
    output logic [15:0] sensor_current_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] s = 16'h3c5a;
    always @(posedge pclk) s <= {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    // y count is only meaningful beside the start pulse, so it wanders elsewhere
    assign matrix_line_start = kick;
    assign matrix_y_count = kick ? ny : s[4:0];
    assign burst_phase = s[0];
    assign source_phase = s[15:8];
    assign sensor_base_count = s;
    assign sensor_current_count = ~s;
endmodule // tac_pad_model

// ---- testbench/tb.sv ----
// ****
// bench: apb traffic, matrix bursts, discharge and pad outputs, interrupt
// ****
// assumes the design, its package and the far-side model compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, kick = 0, slv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d, e;
    logic [31:0] words [8];
    logic [4:0] ny = 5'h0, matrix_y_count;
    logic [15:0] lf = 16'hbdac, sensor_base_count, sensor_current_count, bs, cs;
    logic [511:0] repeat_length_field;
    logic [16:0] sense_pad_group_a_res, sense_pad_group_b_res;
    logic [7:0] discharge_on, spread_max_deviation, source_phase;
    logic [4:0] discharge_trim;
    logic pready, pslverr, matrix_line_start, burst_value_request, matrix_resume, irq;
    logic discharge_global_enable, ref_voltage_select, ref_resistor_select, burst_phase;
    int failures = 0, n_checks = 0, ys[6] = '{4, 0, 5, 3, 9, 30};
    tac_config_regs i_dut (.*);
    tac_pad_model i_pad (.*);
    always #20 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return {lf, lf ^ 16'h5a3c};
    endfunction
    task automatic chk(input logic [32:0] s, input logic [32:0] x);
        n_checks++;
        if (s !== x) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        bs = sensor_base_count;
        cs = sensor_current_count;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 'h5c; a < 'h6c; a += 4) begin
            apb(0, a[7:0], 0);
            chk({slv, rd}, 0);
        end
        apb(1, 8'h58, rnd());
        @(negedge pclk);
        chk(repeat_length_field[31:0], 0);
        apb(0, 8'h00, 0);
        chk({slv, rd}, 33'h1_0000_0000);
        for (int i = 0; i < 6; i++) begin
            d = i == 0 ? 32'hff001f00 : i == 1 ? 32'h00800000 : rnd();
            e = rnd();
            apb(1, 8'h5c, d);
            apb(1, 8'h60, e);
            apb(1, 8'h64, d);
            apb(1, 8'h68, e);
            @(negedge pclk);
            chk(discharge_on, d[23] ? d[31:24] | d[7:0] & source_phase : 8'h00);
            chk({discharge_global_enable, ref_voltage_select, ref_resistor_select,
                discharge_trim}, {d[23], d[17:16], d[12:8]});
            chk(spread_max_deviation, e[7:0]);
            chk(sense_pad_group_a_res, burst_phase ? d[16:0] : 17'h0);
            chk(sense_pad_group_b_res, burst_phase ? e[16:0] : 17'h0);
            apb(0, 8'h5c, 0);
            chk(rd, d & 32'hff831fff);
            apb(0, 8'h6c, 0);
            chk(rd, bs);
            apb(0, 8'h70, 0);
            chk(rd, cs);
        end
        foreach (ys[n]) begin
            @(posedge pclk);
            kick <= 1'b1;
            ny <= ys[n][4:0];
            @(posedge pclk);
            kick <= 1'b0;
            @(negedge pclk);
            chk(burst_value_request, ys[n] != 0);
            for (int w = 0; w * 4 < ys[n]; w++) begin
                words[w] = rnd();
                apb(1, 8'h58, words[w]);
            end
            for (int k = 0; k < 8 && matrix_resume !== 1'b1; k++) @(negedge pclk);
            chk({matrix_resume, burst_value_request}, 2'b10);
            for (int j = 0; j < ys[n]; j++) begin
                chk(repeat_length_field[8*j+:8], words[j/4][8*(3-j%4)+:8]);
            end
        end
        apb(0, 8'h74, 0);
        chk(rd[1:0], 2'b11);
        chk(irq, 0);
        apb(1, 8'h44, 3);
        @(negedge pclk);
        chk(irq, 1);
        apb(1, 8'h40, 3);
        @(negedge pclk);
        chk(irq, 0);
        complete_run();
    end
endmodule // tb
